// ### csf_status_irq.sv
// Purpose: Receiver/transmitter status flags and interrupt requests of a CAN controller
// Assumes: Protocol engine on hclk gives counts and event pulses; one AHB-Lite master
// Notes:   Every data phase takes two cycles; the first one has hreadyout low
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module csf_status_irq (
   input  wire logic        hclk,           // Clock, 40 MHz
   input  wire logic        hresetn,        // Async reset, active low
   input  wire logic        hsel,           // Slave select
   input  wire logic [13:0] haddr,          // Byte address
   input  wire logic [1:0]  htrans,         // Transfer type
   input  wire logic        hwrite,         // Write when high
   input  wire logic [2:0]  hsize,          // Word only
   input  wire logic [31:0] hwdata,         // Write data
   input  wire logic        hready,         // Bus ready
   output logic [31:0]      hrdata,         // Read data
   output logic             hreadyout,      // Slave ready
   output logic             hresp,          // Always OKAY
   input  wire logic        can_rx,         // CAN receive pin
   input  wire logic        sleep_mode,     // Engine is in sleep
   input  wire logic [7:0]  rx_error_count, // Receive error count
   input  wire logic [7:0]  tx_error_count, // Transmit error count
   input  wire logic        bus_off_enter,  // Pulse: transmit count passed 255
   input  wire logic        recessive_seq,  // Pulse: 11 recessive bits seen
   input  wire logic        rx_overrun,     // Pulse: receive overrun
   input  wire logic        rx_msg_ready,   // Level: good message in background
   input  wire logic [2:0]  tx_sent,        // Pulse per buffer: sent
   input  wire logic [2:0]  tx_aborted,     // Pulse per buffer: aborted
   output logic             rx_swap,        // Pulse: copy background to foreground
   output logic [2:0]       abort_request,  // Abort request per buffer
   output logic             soft_reset_active, // Engine held in soft reset
   output logic             bus_off_state,  // Bus-off state held
   output logic             irq_wake,       // Wake interrupt
   output logic             irq_rx,         // Receive interrupt
   output logic             irq_err,        // Error interrupt
   output logic [2:0]       irq_tx          // Transmit-empty interrupts
);
   logic        pend_reg;
   logic        wr_reg;
   logic [13:0] addr_reg;
   logic        soft_rst_reg;
   logic [7:0]  rx_en_reg;
   logic [2:0]  tx_irqen_reg;
   logic [7:0]  recov_reg;
   logic        rx_sync;
   logic        rx_prev_reg;
   logic [7:0]  rx_set;
   logic [7:0]  rx_clr;
   logic [7:0]  rx_flags;
   logic [2:0]  tx_empty;
   logic [2:0]  tx_ack;
   logic [2:0]  empty_clr;
   logic [2:0]  empty_set;
   logic [2:0]  ack_clr;
   logic        swap_now;
   logic        data_cyc;
   logic [7:0]  err_mask;
   logic        take;

   // Decodes whether the stored data-phase address hits a given register
   function automatic logic hit(input logic [13:0] a, input logic [13:0] r);
      hit = (a == r);
   endfunction

   assign take     = hsel & hready & htrans[1];
   assign data_cyc = pend_reg & ~hreadyout;
   assign hresp    = 1'b0;

   // Address phase capture and one wait state per data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_reg  <= 1'b0;
         wr_reg    <= 1'b0;
         addr_reg  <= 14'h0000;
         hreadyout <= 1'b1;
      end else if (take) begin
         pend_reg  <= 1'b1;
         wr_reg    <= hwrite;
         addr_reg  <= haddr;
         hreadyout <= 1'b0;
      end else begin
         pend_reg  <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   // Read data registered in the stall cycle; unmapped reads return zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (data_cyc && !wr_reg) begin
         if (hit(addr_reg, csf_pkg::ADDR_RECEIVER_FLAGS)) begin
            hrdata <= {24'h000000, rx_flags}; // R1
         end else if (hit(addr_reg, csf_pkg::ADDR_RECEIVER_IRQ_ENABLE)) begin
            hrdata <= {24'h000000, rx_en_reg};
         end else if (hit(addr_reg, csf_pkg::ADDR_TRANSMITTER_FLAGS)) begin
            hrdata <= {24'h000000, 1'b0, tx_ack, 1'b0, tx_empty};
         end else if (hit(addr_reg, csf_pkg::ADDR_TRANSMITTER_CONTROL)) begin
            hrdata <= {24'h000000, 1'b0, abort_request, 1'b0, tx_irqen_reg};
         end else if (hit(addr_reg, csf_pkg::ADDR_MODULE_CONTROL_0)) begin
            hrdata <= {24'h000000, 6'h00, bus_off_state, soft_rst_reg};
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // Soft reset request bit; it, the bus-off state and its recovery count survive the held reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_rst_reg <= csf_pkg::SOFT_RST_RST;
      end else if (data_cyc && wr_reg && hit(addr_reg, csf_pkg::ADDR_MODULE_CONTROL_0)) begin
         soft_rst_reg <= hwdata[csf_pkg::SOFT_RESET_BIT]; // R23
      end
   end
   assign soft_reset_active = soft_rst_reg; // R23

   // Receiver interrupt enables, held clear during soft reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_en_reg <= csf_pkg::RX_EN_RST;
      end else if (soft_rst_reg) begin
         rx_en_reg <= csf_pkg::RX_EN_RST; // R3
      end else if (data_cyc && wr_reg && hit(addr_reg, csf_pkg::ADDR_RECEIVER_IRQ_ENABLE)) begin
         rx_en_reg <= hwdata[7:0];
      end
   end

   // Transmit enables and abort requests; software can only set a request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_irqen_reg  <= csf_pkg::TX_RST;
         abort_request <= csf_pkg::TX_RST;
      end else if (soft_rst_reg) begin
         tx_irqen_reg  <= csf_pkg::TX_RST; // R3
         abort_request <= csf_pkg::TX_RST;
      end else begin
         if (data_cyc && wr_reg && hit(addr_reg, csf_pkg::ADDR_TRANSMITTER_CONTROL)) begin
            tx_irqen_reg  <= hwdata[csf_pkg::TX_IRQEN_LSB +: 3];
            abort_request <= (abort_request | hwdata[csf_pkg::TX_ABORT_LSB +: 3]) & ~empty_set;
         end else begin
            abort_request <= abort_request & ~empty_set; // R20
         end
      end
   end

   // Bus-off state and recovery count of recessive sequences
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_off_state <= 1'b0;
         recov_reg     <= 8'h00;
      end else if (bus_off_enter) begin
         bus_off_state <= 1'b1; // R9
         recov_reg     <= 8'h00;
      end else if (bus_off_state && recessive_seq) begin
         if (recov_reg == csf_pkg::RECOVERY_SEQS - 8'h01) begin
            bus_off_state <= 1'b0; // R10
            recov_reg     <= 8'h00;
         end else begin
            recov_reg <= recov_reg + 8'h01;
         end
      end
   end

   // Receive pin synchronised before the wake edge detector
   csf_sync u_rx_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d_in    (can_rx),
      .q_out   (rx_sync)
   );

   // Previous synchronised pin level for the dominant edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rx_sync;
      end
   end

   // Swap only while the foreground buffer is free
   assign swap_now = rx_msg_ready & ~rx_flags[csf_pkg::BIT_RX_FULL] & ~soft_rst_reg; // R12
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_swap <= 1'b0;
      end else begin
         rx_swap <= swap_now; // R12
      end
   end

   // Set conditions; level conditions keep a flag set against a clear
   always_comb begin
      rx_set = 8'h00;
      rx_set[csf_pkg::BIT_WAKE] = sleep_mode & rx_prev_reg & ~rx_sync; // R4
      rx_set[csf_pkg::BIT_RX_WARN] = (rx_error_count >= csf_pkg::WARN_LIMIT) // R5
         & ~rx_flags[csf_pkg::BIT_RX_PASSIVE] & ~rx_flags[csf_pkg::BIT_TX_PASSIVE]
         & ~rx_flags[csf_pkg::BIT_BUS_OFF];
      rx_set[csf_pkg::BIT_TX_WARN] = (tx_error_count >= csf_pkg::WARN_LIMIT) // R6
         & ~rx_flags[csf_pkg::BIT_RX_PASSIVE] & ~rx_flags[csf_pkg::BIT_TX_PASSIVE]
         & ~rx_flags[csf_pkg::BIT_BUS_OFF];
      rx_set[csf_pkg::BIT_RX_PASSIVE] = (rx_error_count > csf_pkg::RX_PASSIVE_ABOVE) // R7
         & ~rx_flags[csf_pkg::BIT_BUS_OFF];
      rx_set[csf_pkg::BIT_TX_PASSIVE] = (tx_error_count >= csf_pkg::TX_PASSIVE_MIN) // R8
         & ~rx_flags[csf_pkg::BIT_BUS_OFF];
      rx_set[csf_pkg::BIT_BUS_OFF] = bus_off_state | bus_off_enter; // R9 R10
      rx_set[csf_pkg::BIT_OVERRUN] = rx_overrun; // R11
      rx_set[csf_pkg::BIT_RX_FULL] = swap_now; // R12
   end

   // Write-one clear strobes
   assign rx_clr = (data_cyc && wr_reg && hit(addr_reg, csf_pkg::ADDR_RECEIVER_FLAGS))
                   ? hwdata[7:0] : 8'h00; // R1
   assign empty_clr = (data_cyc && wr_reg && hit(addr_reg, csf_pkg::ADDR_TRANSMITTER_FLAGS))
                      ? hwdata[csf_pkg::TX_EMPTY_LSB +: 3] : 3'h0; // R17
   assign empty_set = tx_sent | tx_aborted; // R18
   assign ack_clr   = empty_clr & tx_empty & ~empty_set; // R20

   // Eight receiver flags, three transmit-empty and three abort acknowledge flags
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rx
         csf_flag u_flag (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .hold_rst (soft_rst_reg),
            .set      (rx_set[gi]),
            .clr      (rx_clr[gi]),
            .q        (rx_flags[gi])
         ); // R1 R2 R3
      end
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_tx
         csf_flag u_empty (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .hold_rst (soft_rst_reg),
            .set      (empty_set[gi]),
            .clr      (empty_clr[gi]),
            .q        (tx_empty[gi])
         ); // R17 R18
         csf_flag u_ack (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .hold_rst (soft_rst_reg),
            .set      (tx_aborted[gi]),
            .clr      (ack_clr[gi]),
            .q        (tx_ack[gi])
         ); // R21
      end
   endgenerate

   // Error interrupt sources
   assign err_mask = (8'h01 << csf_pkg::BIT_RX_WARN) | (8'h01 << csf_pkg::BIT_TX_WARN)
                   | (8'h01 << csf_pkg::BIT_RX_PASSIVE) | (8'h01 << csf_pkg::BIT_TX_PASSIVE)
                   | (8'h01 << csf_pkg::BIT_BUS_OFF) | (8'h01 << csf_pkg::BIT_OVERRUN);

   // Level interrupt requests from flag-and-enable terms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_wake <= 1'b0;
         irq_rx   <= 1'b0;
         irq_err  <= 1'b0;
         irq_tx   <= 3'h0;
      end else begin
         irq_wake <= rx_flags[csf_pkg::BIT_WAKE] & rx_en_reg[csf_pkg::BIT_WAKE]; // R15 R24
         irq_rx   <= rx_flags[csf_pkg::BIT_RX_FULL] & rx_en_reg[csf_pkg::BIT_RX_FULL]; // R15
         irq_err  <= |(rx_flags & rx_en_reg & err_mask); // R16 R24
         irq_tx   <= tx_empty & tx_irqen_reg; // R22
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Bus timing: address taken, one stall, then ready
   sequence s_stall;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_bus_wait;
      take |=> s_stall;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");

   // A written zero never drops a flag
   property p_w1c_zero;
      !soft_rst_reg |=> ((($past(rx_flags) & ~$past(rx_clr)) & ~rx_flags) == 8'h00);
   endproperty
   a_w1c_zero: assert property (p_w1c_zero) else $error("flag lost without clear"); // R1

   // A still-true warning condition defeats the clear
   property p_clear_blocked;
      (rx_set[csf_pkg::BIT_RX_WARN] && !soft_rst_reg) |=> rx_flags[csf_pkg::BIT_RX_WARN];
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) else $error("warn flag cleared"); // R2

   // Soft reset holds flags and enables at zero
   property p_soft_reset;
      soft_rst_reg |=> (rx_flags == 8'h00) && (rx_en_reg == 8'h00) && (tx_empty == 3'h0)
                       && (tx_ack == 3'h0);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not held"); // R3

   // Receive passive flag follows the receive count
   property p_rx_passive;
      (rx_error_count > csf_pkg::RX_PASSIVE_ABOVE && !rx_flags[csf_pkg::BIT_BUS_OFF]
       && !soft_rst_reg) |=> rx_flags[csf_pkg::BIT_RX_PASSIVE];
   endproperty
   a_rx_passive: assert property (p_rx_passive) else $error("rx passive not set"); // R7

   // Bus-off flag stays while the state is held
   property p_bus_off_held;
      (bus_off_state && !soft_rst_reg) |=> rx_flags[csf_pkg::BIT_BUS_OFF];
   endproperty
   a_bus_off_held: assert property (p_bus_off_held) else $error("bus-off flag cleared"); // R10

   // No copy while the foreground buffer is full
   property p_no_swap;
      rx_flags[csf_pkg::BIT_RX_FULL] |=> !rx_swap;
   endproperty
   a_no_swap: assert property (p_no_swap) else $error("swap while full"); // R12

   // Clearing empty also drops the acknowledge
   property p_ack_follows;
      (ack_clr[0] && !tx_aborted[0] && !soft_rst_reg) |=> !tx_ack[0] && !tx_empty[0];
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("ack not cleared"); // R20

   // Setting empty drops the abort request and shows the buffer empty
   property p_abort_drop;
      (empty_set[0] && !soft_rst_reg) |=> !abort_request[0] && tx_empty[0];
   endproperty
   a_abort_drop: assert property (p_abort_drop) else $error("abort request kept"); // R20

   // Error interrupt level follows its terms one cycle later
   property p_err_irq;
      ##1 irq_err == |($past(rx_flags) & $past(rx_en_reg) & err_mask);
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error irq mismatch"); // R16

   // Transmit interrupts follow empty and enable one cycle later
   property p_tx_irq;
      ##1 irq_tx == ($past(tx_empty) & $past(tx_irqen_reg));
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq mismatch"); // R22
endmodule // csf_status_irq
`default_nettype wire

// ### csf_pkg.sv
// Purpose: Shared constants for the CAN status-flag and interrupt block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   Printed offsets are register indices; byte address is four times the index
// Notes on behaviour
// R1: Receiver flags read back; writing one clears a flag, writing zero does nothing.
// R2: A cleared receiver flag stays set while its setting condition still holds.
// R3: Hard or soft reset clears receiver flags, enables and transmitter flags.
// R4: Bus activity during sleep sets the wake flag; enabled wake flag requests interrupt.
// R5: Receive error count at least 96, no passive or bus-off flag, sets receive warning.
// R6: Transmit error count at least 96, no passive or bus-off flag, sets transmit warning.
// R7: Receive error count above 127 without bus-off flag sets receive passive flag.
// R8: Transmit error count 128 to 255 without bus-off flag sets transmit passive flag.
// R9: Entering bus-off, transmit error count beyond 255, sets the bus-off flag.
// R10: Bus-off flag cannot clear before 128 sequences of 11 recessive bits.
// R11: A receive overrun sets the overrun flag; it feeds the error interrupt.
// R12: A landed message sets buffer-full; no buffer swap happens while it is set.
// R13: Software clears buffer-full by writing one after reading the message.
// R14: Software reads the receive buffer only while buffer-full is set.
// R15: Wake flag and buffer-full flag, each enabled, raise wake and receive interrupts.
// R16: Warning, passive, bus-off and overrun flags, each enabled, share one error interrupt.
// R17: Abort acknowledge bits are read-only; transmit-empty bits clear by writing one.
// R18: Transmit-empty sets after a successful send or a successful abort.
// R19: Software fills a transmit buffer first, then clears its empty flag.
// R20: Clearing transmit-empty clears abort acknowledge; setting it clears abort request.
// R21: Abort acknowledge sets when the message was aborted by request.
// R22: Each transmit buffer requests interrupt while empty and its enable is set.
// R23: Soft reset request aborts traffic at once and drops bus synchronisation.
// R24: Interrupt outputs are levels: OR of flag-and-enable terms.
package csf_pkg;
   // Register indices and byte addresses
   localparam logic [11:0] IDX_MODULE_CONTROL_0    = 12'h500;
   localparam logic [11:0] IDX_RECEIVER_FLAGS      = 12'h504;
   localparam logic [11:0] IDX_RECEIVER_IRQ_ENABLE = 12'h505;
   localparam logic [11:0] IDX_TRANSMITTER_FLAGS   = 12'h506;
   localparam logic [11:0] IDX_TRANSMITTER_CONTROL = 12'h507;
   localparam logic [13:0] ADDR_MODULE_CONTROL_0    = {IDX_MODULE_CONTROL_0, 2'b00};
   localparam logic [13:0] ADDR_RECEIVER_FLAGS      = {IDX_RECEIVER_FLAGS, 2'b00};
   localparam logic [13:0] ADDR_RECEIVER_IRQ_ENABLE = {IDX_RECEIVER_IRQ_ENABLE, 2'b00};
   localparam logic [13:0] ADDR_TRANSMITTER_FLAGS   = {IDX_TRANSMITTER_FLAGS, 2'b00};
   localparam logic [13:0] ADDR_TRANSMITTER_CONTROL = {IDX_TRANSMITTER_CONTROL, 2'b00};
   // Receiver flag and enable bit positions
   localparam int BIT_WAKE       = 7;
   localparam int BIT_RX_WARN    = 6;
   localparam int BIT_TX_WARN    = 5;
   localparam int BIT_RX_PASSIVE = 4;
   localparam int BIT_TX_PASSIVE = 3;
   localparam int BIT_BUS_OFF    = 2;
   localparam int BIT_OVERRUN    = 1;
   localparam int BIT_RX_FULL    = 0;
   // Transmitter flag and control fields
   localparam int TX_EMPTY_LSB  = 0;
   localparam int TX_ACK_LSB    = 4;
   localparam int TX_IRQEN_LSB  = 0;
   localparam int TX_ABORT_LSB  = 4;
   localparam int SOFT_RESET_BIT = 0;
   // Reset values
   localparam logic [7:0] RX_FLAGS_RST = 8'h00;
   localparam logic [7:0] RX_EN_RST    = 8'h00;
   localparam logic [2:0] TX_RST       = 3'h0;
   localparam logic       SOFT_RST_RST = 1'b0;
   // Error count thresholds and bus-off recovery count
   localparam logic [7:0] WARN_LIMIT       = 8'h60;
   localparam logic [7:0] RX_PASSIVE_ABOVE = 8'h7F;
   localparam logic [7:0] TX_PASSIVE_MIN   = 8'h80;
   localparam logic [7:0] RECOVERY_SEQS    = 8'h80;
endpackage

// ### csf_sync.sv
// Purpose: Two-stage synchroniser for a level arriving from a pin
// Assumes: Destination clock hclk
// Notes:   Only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module csf_sync (
   input  wire logic hclk,    // Clock
   input  wire logic hresetn, // Async reset, active low
   input  wire logic d_in,    // Asynchronous level
   output logic      q_out    // Synchronised level
);
   logic meta_reg;

   // Two flops in series, reset to recessive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= 1'b1;
         q_out    <= 1'b1;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule // csf_sync
`default_nettype wire

// ### csf_flag.sv
// Purpose: Sticky flag with write-one clear and held reset
// Assumes: set is a pulse or a level condition from hardware
// Notes:   Set wins over clear, so a still-true condition keeps the flag
`timescale 1ns/100ps
`default_nettype none
module csf_flag (
   input  wire logic hclk,    // Clock
   input  wire logic hresetn, // Async reset, active low
   input  wire logic hold_rst,// Soft reset, holds flag at zero
   input  wire logic set,     // Set condition
   input  wire logic clr,     // Clear strobe
   output logic      q        // Flag value
);
   // Set dominates clear; soft reset dominates both
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= 1'b0;
      end else if (hold_rst) begin
         q <= 1'b0;
      end else begin
         q <= set | (q & ~clr);
      end
   end
endmodule // csf_flag
`default_nettype wire

// ### csf_engine_model.sv
// Purpose: Behavioural protocol engine facing the status block
// Assumes: Driven by tb through its tasks, all on hclk
// Notes:   Aborts only a buffer whose abort request is pending
`timescale 1ns/100ps
`default_nettype none
module csf_engine_model (
   input  wire logic       hclk,           // Clock
   input  wire logic       rx_swap,        // Copy strobe
   input  wire logic [2:0] abort_request,  // Pending aborts
   output logic            can_rx,         // Bus pin, 1 recessive
   output logic            sleep_mode,     // Engine asleep
   output logic [7:0]      rx_error_count, // Receive errors
   output logic [7:0]      tx_error_count, // Transmit errors
   output logic            bus_off_enter,  // Bus-off entry
   output logic            recessive_seq,  // Recessive run seen
   output logic            rx_overrun,     // Overrun event
   output logic            rx_msg_ready,   // Message waiting
   output logic [2:0]      tx_sent,        // Sent per buffer
   output logic [2:0]      tx_aborted      // Aborted per buffer
);
   // Idle bus, no events
   initial begin
      {can_rx, sleep_mode, bus_off_enter, recessive_seq, rx_overrun} = 5'h10;
      {rx_error_count, tx_error_count, rx_msg_ready, tx_sent, tx_aborted} = 23'h0;
   end
   // Background message stands until the block copies it
   always @(posedge hclk) if (rx_swap) rx_msg_ready <= 1'b0;
   // One-cycle events: 0 overrun, 1 bus-off, 2 recessive run, 3 sent, 4 abort
   task automatic pulse(input int k, input int n, input int i);
      repeat (n) begin
         @(posedge hclk);
         case (k)
            0: rx_overrun <= 1'b1;
            1: bus_off_enter <= 1'b1;
            2: recessive_seq <= 1'b1;
            3: tx_sent[i] <= 1'b1;
            default: tx_aborted[i] <= abort_request[i];
         endcase
         @(posedge hclk);
         {rx_overrun, bus_off_enter, recessive_seq, tx_sent, tx_aborted} <= 9'h0;
      end
   endtask
   task automatic counts(input logic [7:0] r, input logic [7:0] t);
      @(posedge hclk);
      rx_error_count <= r;
      tx_error_count <= t;
   endtask
   task automatic msg;
      @(posedge hclk);
      rx_msg_ready <= 1'b1;
   endtask
   // Dominant edge while asleep
   task automatic wake;
      @(posedge hclk);
      sleep_mode <= 1'b1;
      @(posedge hclk);
      can_rx <= 1'b0;
      repeat (6) @(posedge hclk);
      can_rx <= 1'b1;
      sleep_mode <= 1'b0;
   endtask
endmodule // csf_engine_model
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the status-flag block
// Assumes: One AHB-Lite master, hready looped from hreadyout
// Notes:   m_rxf, m_en and m_txf model the flag and enable registers; other reads use literals
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [13:0] RF = csf_pkg::ADDR_RECEIVER_FLAGS;
   localparam logic [13:0] RE = csf_pkg::ADDR_RECEIVER_IRQ_ENABLE;
   localparam logic [13:0] TF = csf_pkg::ADDR_TRANSMITTER_FLAGS;
   localparam logic [13:0] TC = csf_pkg::ADDR_TRANSMITTER_CONTROL;
   localparam logic [13:0] MC = csf_pkg::ADDR_MODULE_CONTROL_0;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [13:0] haddr = 14'h0000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, irq_tx, abort_request, tx_sent, tx_aborted;
   logic [31:0] hwdata = 32'h0, hrdata, lf = 32'h24A9441F;
   logic        hreadyout, hresp, rx_swap, soft_reset_active, bus_off_state, irq_wake;
   logic        irq_rx, irq_err, can_rx, sleep_mode, bus_off_enter, recessive_seq;
   logic        rx_overrun, rx_msg_ready;
   logic [7:0]  rx_error_count, tx_error_count, m_rxf = 8'h00, m_en, m_txf = 8'h00;
   int          bad_count = 0, compares = 0, cyc = 0, n;
   // Clock and instances
   always #12.5 hclk = ~hclk;
   csf_status_irq dut (.*, .hready(hreadyout));
   csf_engine_model eng (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Single word transfer: address phase, then data phase, each until ready
   task automatic bus(input logic [13:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(hrdata, {24'h0, e});
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge hclk);
   endtask
   // Counts copy strobes over six cycles
   task automatic swaps(input int e);
      n = 0;
      repeat (6) begin
         @(posedge hclk);
         n += (rx_swap === 1'b1);
      end
      chk(n, e);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         finish_test;
      end
   end
   // Main sequence
   initial begin
      wt(20);
      hresetn <= 1'b1;
      rd(RF, 8'h00);
      rd(TF, 8'h00);
      rd(14'h0100, 8'h00);
      chk(hresp, 1'b0);
      lf = lfsr(lf);
      m_en = lf[7:0];
      wr(RE, m_en);
      rd(RE, m_en);
      m_en = 8'hFF;
      wr(RE, m_en);
      wr(TC, 8'h07);
      rd(TC, 8'h07);
      // Overrun, masking, write-zero and write-one
      eng.pulse(0, 1, 0);
      m_rxf = 8'h02;
      wt(2);
      chk(irq_err, 1'b1);
      wr(RE, 8'hFD);
      wt(3);
      chk(irq_err, 1'b0);
      wr(RE, m_en);
      wr(RF, 8'h00);
      rd(RF, m_rxf);
      wr(RF, 8'h02);
      m_rxf = 8'h00;
      rd(RF, m_rxf);
      chk(irq_err, 1'b0);
      // Count thresholds at their boundaries
      eng.counts(8'h5F, 8'h5F);
      wt(3);
      rd(RF, m_rxf);
      eng.counts(8'h60, 8'h60);
      m_rxf = 8'h60;
      wt(3);
      wr(RF, 8'h60);
      rd(RF, m_rxf);
      eng.counts(8'h7F, 8'h7F);
      wt(3);
      rd(RF, m_rxf);
      eng.counts(8'h80, 8'h80);
      m_rxf = 8'h78;
      wt(3);
      rd(RF, m_rxf);
      eng.counts(8'h00, 8'h00);
      wr(RF, 8'hFF);
      m_rxf = 8'h00;
      rd(RF, m_rxf);
      // Bus-off and its recovery count
      eng.pulse(1, 1, 0);
      m_rxf = 8'h04;
      wt(2);
      wr(RF, 8'h04);
      rd(RF, m_rxf);
      rd(MC, 8'h02);
      chk(bus_off_state, 1'b1);
      eng.pulse(2, 127, 0);
      wr(RF, 8'h04);
      rd(RF, m_rxf);
      eng.pulse(2, 1, 0);
      wt(2);
      wr(RF, 8'h04);
      m_rxf = 8'h00;
      rd(RF, m_rxf);
      chk(bus_off_state, 1'b0);
      // Receive buffer handshake
      eng.msg;
      m_rxf = 8'h01;
      swaps(1);
      chk(irq_rx, 1'b1);
      eng.msg;
      swaps(0);
      rd(RF, m_rxf);
      wr(RF, 8'h01);
      swaps(1);
      wr(RF, 8'h01);
      m_rxf = 8'h00;
      rd(RF, m_rxf);
      // Wake-up
      eng.wake;
      m_rxf = 8'h80;
      wt(2);
      chk(irq_wake, 1'b1);
      rd(RF, m_rxf);
      // Transmit buffers: send, schedule, abort, release
      for (int i = 0; i < 3; i++) begin
         eng.pulse(3, 1, i);
         m_txf = 8'h01 << i;
         wt(2);
         chk(irq_tx[i], 1'b1);
         rd(TF, m_txf);
         wr(TF, m_txf);
         wr(TC, 8'h07 | (8'h10 << i));
         chk(abort_request[i], 1'b1);
         eng.pulse(4, 1, i);
         m_txf = 8'h11 << i;
         wt(2);
         chk(abort_request[i], 1'b0);
         wr(TF, 8'h70);
         rd(TF, m_txf);
         wr(TF, m_txf);
         m_txf = 8'h00;
         rd(TF, m_txf);
      end
      // Soft reset holds the registers cleared
      wr(MC, 8'h01);
      chk(soft_reset_active, 1'b1);
      rd(MC, 8'h01);
      rd(TC, 8'h00);
      rd(RF, 8'h00);
      rd(RE, 8'h00);
      chk(irq_wake, 1'b0);
      eng.pulse(0, 1, 0);
      rd(RF, 8'h00);
      wr(MC, 8'h00);
      rd(RE, 8'h00);
      finish_test;
   end
endmodule // tb
`default_nettype wire
